// ### inc/umcs_params.svh
/*
  Constants of the modem control and status block: register offsets,
  field positions, reset values and prescaler count.
  Assumes inclusion by the package, the checker and the bench by bare name.
*/
`ifndef UMCS_PARAMS_SVH
`define UMCS_PARAMS_SVH

// register offsets on the plain register port
`define UMCS_OFS_CTRL 3'h0
`define UMCS_OFS_STAT 3'h1
`define UMCS_OFS_ISTAT 3'h2
`define UMCS_OFS_IMASK 3'h3
`define UMCS_OFS_CFG 3'h4

// modem control field positions
`define UMCS_MC_PRESCALE 7
`define UMCS_MC_THRESH 6
`define UMCS_MC_XONANY 5
`define UMCS_MC_LOOP 4
`define UMCS_MC_IRQOP 3
`define UMCS_MC_FIFORDY 2
`define UMCS_MC_RTS 1
`define UMCS_MC_DTR 0

// config register field positions
`define UMCS_CFG_EFRWE 0
`define UMCS_CFG_AUTORTS 1

// reset values
`define UMCS_RST_CTRL 8'h00
`define UMCS_RST_CFG 2'h0
`define UMCS_RST_IMASK 4'h0
`define UMCS_RST_PIN 1'h1

// prescaler counts up to this value, so it divides by four input clocks when selected
`define UMCS_PRESCALE_DIV 2'h3

`endif

// ### inc/umcs_pkg.sv
/*
  Types of the modem control and status block.
  Assumes umcs_params.svh is on the include path.
*/
`include "umcs_params.svh"

package umcs_pkg;

  // active-low modem inputs as seen at the pins
  typedef struct packed {
    logic cdN;
    logic riN;
    logic dsrN;
    logic ctsN;
  } umcs_pins_t;

  // line-side outputs
  typedef struct packed {
    logic rtsN;
    logic dtrN;
    logic gpOutN;
    logic intOutEn;
  } umcs_line_t;

  // mode bits handed to the rest of the channel
  typedef struct packed {
    logic prescaleDiv4;
    logic thresholdAccessEn;
    logic xonAnyEn;
    logic fifoRdyEn;
    logic loopbackEn;
  } umcs_mode_t;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } umcs_req_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] cfg;
    logic [3:0] delta;
    logic [3:0] prevSrc;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [3:0] irqStat;
    logic [3:0] irqMask;
    logic [7:0] rdData;
    logic [1:0] preCnt;
    logic baudTick;
  } umcs_state_t;

endpackage

// ### design/umcs_modem.sv
/*
  Modem control and modem status logic of one UART channel, with a
  small register port, change interrupt and clock prescaler.
  Assumes a single 10 MHz clock, a register master that holds its
  strobes one cycle, and modem pins asynchronous to the clock.
*/
// Functional notes
// - control bit 7 set divides the input clock by four for baud.
// - control bit 6 set enables access to threshold/trigger registers.
// - control bit 5 enables resume-on-any-character.
// - control bit 4 loops transmit to receive and control to status.
// - control bit 3 low floats interrupt outputs, general output high.
// - control bit 2 enables the combined FIFO-ready register.
// - control bit 1 drives request-to-send low; auto mode overrides.
// - control bit 0 drives terminal-ready low; loop-back feeds status 5.
// - control bits 7..5 writable only with enhanced write-enable set.
// - normal mode status 7..4 are inverted CD, RI, DSR, CTS inputs.
// - loop-back status 7,6,5,4 equal control bits 3,2,0,1.
// - CD, DSR, CTS change flags set on any edge, clear on read.
// - RI change flag sets on falling status (pin going high), on rising in loop-back, clears on read.
`timescale 1ns/100ps

module umcs_modem
  import umcs_pkg::*;
(
  input wire logic clock, // 10 MHz clock
  input wire logic rst_n, // asynchronous reset
  input wire umcs_req_t req, // register port request
  output logic [7:0] rdata, // read data, cycle after read
  input wire umcs_pins_t pins, // active-low modem inputs
  input wire logic rxPin, // serial receive pin
  input wire logic txSerial, // serial transmit from transmitter
  input wire logic flowRtsActive, // hardware flow rts request
  output logic rxSerial, // serial data to the receiver
  output umcs_line_t line, // line-side outputs
  output umcs_mode_t mode, // mode bits to the channel
  output logic baudTick, // baud generator clock enable
  output logic irq // level interrupt
);

  //////////////////////////////////////////////////////////////////////
  // state

  umcs_state_t state_reg;
  umcs_state_t state_next;

  logic loopOn;
  logic [3:0] srcNow;
  logic [3:0] statusHi;
  logic [3:0] riseEv;
  logic [3:0] anyEv;
  logic [3:0] setDelta;
  logic rdStat;
  logic wrCtrl;
  logic [7:0] ctrlWrMasked;

  //////////////////////////////////////////////////////////////////////
  // combinational helpers

  assign loopOn = state_reg.ctrl[`UMCS_MC_LOOP];

  // sources in status order: cd, ri, dsr, cts, active high
  always_comb begin
    if (loopOn) begin
      srcNow = {state_reg.ctrl[`UMCS_MC_IRQOP],
                state_reg.ctrl[`UMCS_MC_FIFORDY],
                state_reg.ctrl[`UMCS_MC_DTR],
                state_reg.ctrl[`UMCS_MC_RTS]};
    end else begin
      srcNow = ~state_reg.sync2[3:0];
    end
  end

  assign statusHi = srcNow;

  // edges are taken on the synchronised copy, so each pin change
  // raises one event only
  assign anyEv = srcNow ^ state_reg.prevSrc;
  // ring flag: the pin going high is a falling status bit, while in
  // loop-back the control bit itself rising is the event
  always_comb begin
    riseEv = srcNow & ~state_reg.prevSrc;
    if (!loopOn) begin
      riseEv[2] = ~srcNow[2] & state_reg.prevSrc[2];
    end
  end

  always_comb begin
    setDelta = '0;
    setDelta[3] = anyEv[3];
    setDelta[2] = riseEv[2];
    setDelta[1] = anyEv[1];
    setDelta[0] = anyEv[0];
  end

  assign rdStat = req.rd && (req.addr == `UMCS_OFS_STAT);
  assign wrCtrl = req.wr && (req.addr == `UMCS_OFS_CTRL);

  // upper control bits keep their value unless write-enabled
  always_comb begin
    ctrlWrMasked = req.wdata;
    if (!state_reg.cfg[`UMCS_CFG_EFRWE]) begin
      ctrlWrMasked[7:5] = state_reg.ctrl[7:5];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_next = state_reg;

    // two-stage synchronisers for pins and rx
    state_next.sync1 = {rxPin, pins};
    state_next.sync2 = state_reg.sync1;
    state_next.prevSrc = srcNow;

    // change flags: a new event beats the clear-on-read
    if (rdStat) begin
      state_next.delta = setDelta;
    end else begin
      state_next.delta = state_reg.delta | setDelta;
    end

    // interrupt status: write one to clear, set wins
    state_next.irqStat = state_reg.irqStat | setDelta;
    if (req.wr && (req.addr == `UMCS_OFS_ISTAT)) begin
      state_next.irqStat = (state_reg.irqStat & ~req.wdata[3:0])
                           | setDelta;
    end

    // register writes
    if (wrCtrl) begin
      state_next.ctrl = ctrlWrMasked;
    end else if (req.wr && (req.addr == `UMCS_OFS_IMASK)) begin
      state_next.irqMask = req.wdata[3:0];
    end else if (req.wr && (req.addr == `UMCS_OFS_CFG)) begin
      state_next.cfg = req.wdata[1:0];
    end

    // read data, valid in the cycle after the strobe
    state_next.rdData = 8'h00;
    if (req.rd) begin
      if (req.addr == `UMCS_OFS_CTRL) begin
        state_next.rdData = state_reg.ctrl;
      end else if (req.addr == `UMCS_OFS_STAT) begin
        state_next.rdData = {statusHi, state_reg.delta};
      end else if (req.addr == `UMCS_OFS_ISTAT) begin
        state_next.rdData = {4'h0, state_reg.irqStat};
      end else if (req.addr == `UMCS_OFS_IMASK) begin
        state_next.rdData = {4'h0, state_reg.irqMask};
      end else if (req.addr == `UMCS_OFS_CFG) begin
        state_next.rdData = {6'h00, state_reg.cfg};
      end else begin
        state_next.rdData = 8'h00;
      end
    end

    // prescaler: a tick every clock, or every fourth when selected
    if (state_reg.ctrl[`UMCS_MC_PRESCALE]) begin
      if (state_reg.preCnt == `UMCS_PRESCALE_DIV) begin
        state_next.preCnt = 2'h0;
        state_next.baudTick = 1'b1;
      end else begin
        state_next.preCnt = state_reg.preCnt + 2'h1;
        state_next.baudTick = 1'b0;
      end
    end else begin
      state_next.preCnt = 2'h0;
      state_next.baudTick = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.ctrl <= `UMCS_RST_CTRL;
      state_reg.cfg <= `UMCS_RST_CFG;
      state_reg.delta <= 4'h0;
      state_reg.prevSrc <= 4'h0;
      state_reg.sync1 <= {5{`UMCS_RST_PIN}};
      state_reg.sync2 <= {5{`UMCS_RST_PIN}};
      state_reg.irqStat <= 4'h0;
      state_reg.irqMask <= `UMCS_RST_IMASK;
      state_reg.rdData <= 8'h00;
      state_reg.preCnt <= 2'h0;
      state_reg.baudTick <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata = state_reg.rdData;
  assign baudTick = state_reg.baudTick;
  assign irq = |(state_reg.irqStat & state_reg.irqMask);

  // in loop-back the receiver hears our own transmitter
  assign rxSerial = loopOn ? txSerial : state_reg.sync2[4];

  always_comb begin
    line.intOutEn = state_reg.ctrl[`UMCS_MC_IRQOP];
    line.gpOutN = ~state_reg.ctrl[`UMCS_MC_IRQOP];
    line.dtrN = ~state_reg.ctrl[`UMCS_MC_DTR];
    if (state_reg.cfg[`UMCS_CFG_AUTORTS]) begin
      line.rtsN = ~flowRtsActive;
    end else begin
      line.rtsN = ~state_reg.ctrl[`UMCS_MC_RTS];
    end
  end

  always_comb begin
    mode.prescaleDiv4 = state_reg.ctrl[`UMCS_MC_PRESCALE];
    mode.thresholdAccessEn = state_reg.ctrl[`UMCS_MC_THRESH];
    mode.xonAnyEn = state_reg.ctrl[`UMCS_MC_XONANY];
    mode.fifoRdyEn = state_reg.ctrl[`UMCS_MC_FIFORDY];
    mode.loopbackEn = loopOn;
  end

endmodule // umcs_modem

// ### dv/umcs_modem_properties.sv
/* port checker of the modem block.
   assumes a bind onto umcs_modem, one clock domain. */
`timescale 1ns/100ps
`include "umcs_params.svh"
module umcs_modem_properties
  import umcs_pkg::*;
(
  input wire logic clock, // clock
  input wire logic rst_n, // reset
  input wire umcs_req_t req, // request
  input wire logic [7:0] rdata, // read data
  input wire umcs_pins_t pins, // modem lines
  input wire logic rxSerial, // to receiver
  input wire umcs_line_t line, // line side
  input wire umcs_mode_t mode, // mode bits
  input wire logic baudTick // baud enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  logic [3:0] lowCtrl_reg; // control bits 3..0 are never write-guarded
  logic ctlWr;
  logic stRd;
  assign ctlWr = req.wr && req.addr == `UMCS_OFS_CTRL;
  assign stRd = req.rd && req.addr == `UMCS_OFS_STAT;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) lowCtrl_reg <= 4'h0;
    else if (ctlWr) lowCtrl_reg <= req.wdata[3:0];
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_gap; !baudTick [*3] ##1 baudTick; endsequence
  sequence s_off; ##[0:3] !mode.prescaleDiv4; endsequence
  property p_dtr; ctlWr |=> line.dtrN == !$past(req.wdata[0]); endproperty
  property p_op;
    ctlWr |=> line.intOutEn == $past(req.wdata[3]) && line.gpOutN != line.intOutEn;
  endproperty
  property p_mode;
    ctlWr |=> mode.loopbackEn == $past(req.wdata[4])
      && mode.fifoRdyEn == $past(req.wdata[2]);
  endproperty
  property p_fast;
    !mode.prescaleDiv4 && !$past(mode.prescaleDiv4) && $past(rst_n) |-> baudTick;
  endproperty
  // a few settled cycles first, the last undivided tick may linger
  property p_slow;
    mode.prescaleDiv4 && $past(mode.prescaleDiv4, 5) && baudTick
      |=> s_gap or s_off;
  endproperty
  property p_norm;
    stRd && !mode.loopbackEn && !$past(mode.loopbackEn) && $stable(pins)
      && $past(pins, 3) == pins |=> rdata[7:4] == ~$past(pins);
  endproperty
  property p_loop;
    stRd && mode.loopbackEn && $past(mode.loopbackEn, 3)
      && $past(lowCtrl_reg, 3) == lowCtrl_reg |=> rdata[7:4] ==
      {$past(lowCtrl_reg[3:2]), $past(lowCtrl_reg[0]), $past(lowCtrl_reg[1])};
  endproperty
  property p_unmap; req.rd && req.addr > 3'h4 |=> rdata == 8'h00; endproperty
  a_dtr: assert property (p_dtr) else $error("dtr level");
  a_op: assert property (p_op) else $error("output enable");
  a_mode: assert property (p_mode) else $error("mode bits");
  a_fast: assert property (p_fast) else $error("undivided tick");
  a_slow: assert property (p_slow) else $error("divided tick");
  a_norm: assert property (p_norm) else $error("status lines");
  a_loop: assert property (p_loop) else $error("loop status");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule // umcs_modem_properties

bind umcs_modem umcs_modem_properties i_props (.clock(clock), .rst_n(rst_n),
  .req(req), .rdata(rdata), .pins(pins), .rxSerial(rxSerial), .line(line),
  .mode(mode), .baudTick(baudTick));

// ### dv/umcs_modem_model.sv
/* modem side model: drives the active-low lines and the rx pin.
   assumes the bench sets the wanted line levels on pinLvl. */
`timescale 1ns/100ps
module umcs_modem_model
  import umcs_pkg::*;
(
  input wire logic clock, // bench clock
  input wire logic [3:0] pinLvl, // wanted cd, ri, dsr, cts levels
  output umcs_pins_t pins, // active-low lines
  output logic rxPin // held at the idle mark level
);
  initial begin
    pins = 4'hf;
    rxPin = 1'b1;
  end
  // lines move well off the edge: a real modem is not synchronous
  always @(posedge clock) pins <= #37 pinLvl;
endmodule // umcs_modem_model

// ### dv/tb.sv
/* self-checking bench of the modem control and status block.
   assumes the modem model and the checker are compiled alongside. */
`timescale 1ns/100ps
`include "umcs_params.svh"
module tb
  import umcs_pkg::*;
;
  logic clock, rst_n, txSerial, flowRtsActive, rxPin, rxSerial, baudTick, irq;
  logic [7:0] rdata;
  logic [3:0] pinLvl;
  umcs_req_t req;
  umcs_pins_t pins;
  umcs_line_t line;
  umcs_mode_t mode;
  int num_errors = 0;
  int compares = 0;
  umcs_modem i_dut (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
    .pins(pins), .rxPin(rxPin), .txSerial(txSerial),
    .flowRtsActive(flowRtsActive), .rxSerial(rxSerial), .line(line),
    .mode(mode), .baudTick(baudTick), .irq(irq));
  umcs_modem_model i_model (.clock(clock), .pinLvl(pinLvl), .pins(pins),
    .rxPin(rxPin));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock) req.wr <= 1'b0;
    @(negedge clock);
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock) req.rd <= 1'b0;
    @(negedge clock) chk(rdata === e, "read data");
  endtask
  task lvl(input logic [3:0] v);
    @(posedge clock) pinLvl <= v;
    repeat (6) @(negedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_lines();
    chk(line === 4'he, "reset lines");
    rd(`UMCS_OFS_CTRL, 8'h00);
    rd(3'h7, 8'h00);
    wr(`UMCS_OFS_CTRL, 8'h0b);
    chk(line === 4'h1, "lines driven");
    wr(`UMCS_OFS_CTRL, 8'h02);
    wr(`UMCS_OFS_CFG, 8'h02);
    chk(line.rtsN === 1'b1, "auto rts idle");
    @(posedge clock) flowRtsActive <= 1'b1;
    @(negedge clock) chk(line.rtsN === 1'b0, "auto rts on");
    wr(`UMCS_OFS_CFG, 8'h00);
  endtask
  task t_guard();
    int n;
    n = 0;
    wr(`UMCS_OFS_CTRL, 8'he0);
    rd(`UMCS_OFS_CTRL, 8'h00);
    wr(`UMCS_OFS_CFG, 8'h01);
    wr(`UMCS_OFS_CTRL, 8'he4);
    rd(`UMCS_OFS_CTRL, 8'he4);
    chk(mode === 5'h1e, "mode bits");
    repeat (2) @(negedge clock);
    repeat (8) @(negedge clock) n += baudTick;
    chk(n == 2, "tick rate");
    wr(`UMCS_OFS_CTRL, 8'h00);
    wr(`UMCS_OFS_CFG, 8'h00);
  endtask
  task t_status();
    rd(`UMCS_OFS_STAT, 8'h00);
    lvl(4'h0);
    rd(`UMCS_OFS_STAT, 8'hfb);
    rd(`UMCS_OFS_STAT, 8'hf0);
    lvl(4'hf);
    rd(`UMCS_OFS_STAT, 8'h0f);
  endtask
  task t_irq();
    wr(`UMCS_OFS_ISTAT, 8'h0f);
    wr(`UMCS_OFS_IMASK, 8'h01);
    chk(irq === 1'b0, "irq idle");
    lvl(4'he);
    chk(irq === 1'b1, "irq raised");
    wr(`UMCS_OFS_IMASK, 8'h00);
    chk(irq === 1'b0, "irq masked");
    wr(`UMCS_OFS_IMASK, 8'h01);
    wr(`UMCS_OFS_ISTAT, 8'h01);
    chk(irq === 1'b0, "irq cleared");
    rd(`UMCS_OFS_ISTAT, 8'h00);
    rd(`UMCS_OFS_STAT, 8'h11);
  endtask
  task t_loop();
    wr(`UMCS_OFS_CTRL, 8'h15);
    @(posedge clock) txSerial <= 1'b0;
    repeat (4) @(negedge clock);
    chk(rxSerial === 1'b0, "tx looped");
    rd(`UMCS_OFS_STAT, 8'h67);
    wr(`UMCS_OFS_CTRL, 8'h12);
    repeat (4) @(negedge clock);
    rd(`UMCS_OFS_STAT, 8'h13);
    wr(`UMCS_OFS_CTRL, 8'h00);
    repeat (4) @(negedge clock);
    chk(rxSerial === 1'b1, "rx pin back");
  endtask
  task tally_and_finish();
    $display("mismatches %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    req = '0;
    txSerial = 1'b1;
    flowRtsActive = 1'b0;
    pinLvl = 4'hf;
    repeat (3) @(posedge clock);
    @(posedge clock) rst_n <= 1'b1;
    @(negedge clock);
    t_lines();
    t_guard();
    t_status();
    t_irq();
    t_loop();
    tally_and_finish();
  end
endmodule // tb
